// >>> design/legacy_dma_misc_config_regs.sv
/*
 * configuration-space registers of the audio function: second distributed
 * dma channel base/enable and the miscellaneous configuration register,
 * with the controls they steer (dsp clock duty, music retry, serial port
 * clock, pc/pci sideband setup).
 * assumes configuration cycles already decoded to this function by the pci
 * target, presented as one-cycle read or write strobes on dword addresses.
 */
`timescale 1ns/100ps

// Contract
// - nine-bit base in bits 15:7, read back
// - bits 5:4 hold writable channel number
// - reserved bits 6 and 3:1 read zero
// - bit 0 enables second dma channel
// - bits 7:6 set dsp clock duty
// - bit 5 retries full music register hits
// - bit 4 picks 400 KHz or pci clock
// - bits 2:1 channel code, only in sideband mode
// - bit 0 enables sideband request and grant
module legacy_dma_misc_config_regs
	import cfg_space_pkg::*;
(
	input wire logic clock_i, // pci clock, 20 MHz
	input wire logic reset_i, // pci reset, synchronous, active high
	input wire logic cfg_rd_i, // configuration read strobe
	input wire logic cfg_wr_i, // configuration write strobe
	input wire logic [cfg_space_pkg::DWORD_ADDR_W-1:0] cfg_dword_i, // dword index
	input wire logic [3:0] cfg_be_i, // byte enables, active high
	input wire logic [31:0] cfg_wdata_i, // write data
	output logic [31:0] cfg_rdata_o, // read data
	output logic cfg_ack_o, // access completed
	output logic [8:0] second_dma_base_o, // channel base address bits 15:7
	output logic [1:0] second_dma_chan_o, // channel number field
	output logic second_dma_on_o, // second channel enabled
	output logic [1:0] dsp_clock_duty_sel_o, // dsp clock duty select
	output logic bus_hog_fix_on_o, // bus hog fix enable
	input wire logic synth_queue_first_hit_i, // target access hits first music reg
	input wire logic synth_queue_second_hit_i, // target access hits second music reg
	input wire logic synth_queue_first_full_i, // first music register full
	input wire logic synth_queue_second_full_i, // second music register full
	output logic synth_retry_o, // target must answer retry
	output logic serial_cfg_port_clock_sel_o, // 1 = pci clock on serial port
	output logic scp_clock_o, // serial configuration port clock
	input wire logic scp_data_i, // serial configuration port data pin
	output logic scp_data_o, // sampled serial data
	output logic scp_sample_o, // pulse on each new sample, 400 KHz mode only
	output logic sideband_dma_mode_on_o, // pc/pci mode enabled
	output logic [1:0] legacy_dma_channel_code_o, // encoded legacy dma channel
	input wire logic legacy_dma_req_i, // internal legacy dma wants service
	output logic sideband_req_o, // sideband request pin level
	input wire logic sideband_gnt_i, // sideband grant pin
	output logic legacy_dma_gnt_o // grant toward internal legacy dma
);
	logic [15:0] second_dma_base_q;
	logic [15:0] second_dma_base_d;
	logic [7:0] misc_config_q;
	logic [7:0] misc_config_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic ack_q;
	logic gnt_meta_q;
	logic gnt_sync_q;
	logic gnt_q;
	logic base_sel;
	logic misc_sel;
	logic [7:0] base_lo_wdata;
	logic [7:0] base_hi_wdata;
	logic [7:0] misc_wdata;
	logic base_lo_we;
	logic base_hi_we;
	logic misc_we;
	logic sideband_on;

	// address decode: two dwords carry our registers, everything else reads zero
	assign base_sel = (cfg_dword_i == SECOND_DMA_BASE_DWORD);
	assign misc_sel = (cfg_dword_i == MISC_CONFIG_DWORD);

	// byte lane write enables
	assign base_lo_we = cfg_wr_i && base_sel && cfg_be_i[SECOND_DMA_BASE_LANE];
	assign base_hi_we = cfg_wr_i && base_sel && cfg_be_i[SECOND_DMA_BASE_LANE + 1];
	assign misc_we = cfg_wr_i && misc_sel && cfg_be_i[MISC_CONFIG_LANE];

	// lane data; reserved bits masked so they can never be stored
	assign base_lo_wdata = cfg_wdata_i[8*SECOND_DMA_BASE_LANE +: 8] & BASE_LOW_BYTE_MASK;
	assign base_hi_wdata = cfg_wdata_i[8*(SECOND_DMA_BASE_LANE+1) +: 8] & BASE_HIGH_BYTE_MASK;
	assign misc_wdata = cfg_wdata_i[8*MISC_CONFIG_LANE +: 8] & MISC_CONFIG_MASK;

	// next register values per byte lane
	assign second_dma_base_d = {
		base_hi_we ? base_hi_wdata : second_dma_base_q[15:8],
		base_lo_we ? base_lo_wdata : second_dma_base_q[7:0]
	};
	assign misc_config_d = misc_we ? misc_wdata : misc_config_q;

	// read mux: register content placed in its own lane, other lanes zero
	assign rdata_d = base_sel ? {second_dma_base_q, 16'h0000} :
		misc_sel ? {24'h000000, misc_config_q} :
		32'h00000000;

	// second dma base storage; reserved bits never load, so they read zero
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			second_dma_base_q <= SECOND_DMA_BASE_RESET;
		end
		else
		begin
			second_dma_base_q <= second_dma_base_d;
		end
	end

	// miscellaneous register storage
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			misc_config_q <= MISC_CONFIG_RESET;
		end
		else
		begin
			misc_config_q <= misc_config_d;
		end
	end

	// read data captured with the strobe and held until the next read
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			rdata_q <= 32'h00000000;
		end
		else
		begin
			rdata_q <= cfg_rd_i ? rdata_d : rdata_q;
		end
	end

	// completion one cycle after any strobe; nothing is ever refused
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			ack_q <= 1'b0;
		end
		else
		begin
			ack_q <= cfg_rd_i || cfg_wr_i;
		end
	end

	assign cfg_rdata_o = rdata_q;
	assign cfg_ack_o = ack_q;

	// second dma channel controls straight from the register
	assign second_dma_base_o = second_dma_base_q[BASE_ADDR_HI:BASE_ADDR_LO];
	assign second_dma_chan_o = second_dma_base_q[BASE_CHAN_HI:BASE_CHAN_LO];
	assign second_dma_on_o = second_dma_base_q[BASE_ENABLE_BIT];

	// the channel numbers are not cross-checked here; the chipset owns that choice
	// and both channel fields are left exactly as software wrote them

	// miscellaneous controls
	assign dsp_clock_duty_sel_o = misc_config_q[MISC_DUTY_HI:MISC_DUTY_LO];
	assign bus_hog_fix_on_o = misc_config_q[MISC_BUS_HOG_BIT];
	assign serial_cfg_port_clock_sel_o = misc_config_q[MISC_SCP_CLOCK_BIT];

	// retry is combinational so the target can answer in the same data phase
	assign synth_retry_o = misc_config_q[MISC_RETRY_BIT] &&
		((synth_queue_first_hit_i && synth_queue_first_full_i) ||
		(synth_queue_second_hit_i && synth_queue_second_full_i));

	// sideband mode: channel code only meaningful while enabled
	assign sideband_on = misc_config_q[MISC_SIDEBAND_BIT];
	assign sideband_dma_mode_on_o = sideband_on;
	assign legacy_dma_channel_code_o = sideband_on ?
		misc_config_q[MISC_CHAN_HI:MISC_CHAN_LO] : 2'h0;

	// grant pin crosses in through two flops; only the second is read further on
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			gnt_meta_q <= 1'b0;
			gnt_sync_q <= 1'b0;
		end
		else
		begin
			gnt_meta_q <= sideband_gnt_i;
			gnt_sync_q <= gnt_meta_q;
		end
	end

	// registered grant, gated by the mode bit so a stray pin level never leaks
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			gnt_q <= 1'b0;
		end
		else
		begin
			gnt_q <= sideband_on && gnt_sync_q;
		end
	end

	// request goes inactive with the mode bit; the registered grant follows one cycle later
	assign sideband_req_o = sideband_on && legacy_dma_req_i;
	assign legacy_dma_gnt_o = gnt_q;

	// serial configuration port clock and data sampling
	serial_cfg_clock scp_clock_unit (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.pci_clock_sel_i(misc_config_q[MISC_SCP_CLOCK_BIT]),
		.data_i(scp_data_i),
		.scp_clock_o(scp_clock_o),
		.data_o(scp_data_o),
		.sample_o(scp_sample_o)
	);

endmodule

// >>> design/cfg_space_pkg.sv
/*
 * constants for the audio function's dma base and miscellaneous
 * configuration registers: offsets, field positions, masks, reset values
 * and the serial configuration port clock timing.
 * assumes a single 20 MHz system clock and 6-bit configuration dword addresses.
 */
package cfg_space_pkg;

	// configuration dword index width (byte address bits 7:2)
	localparam int DWORD_ADDR_W = 6;

	// printed byte offsets of the two registers
	localparam logic [7:0] SECOND_DMA_BASE_OFFSET = 8'h42;
	localparam logic [7:0] MISC_CONFIG_OFFSET = 8'h58;

	// dword indexes derived from the byte offsets
	localparam logic [DWORD_ADDR_W-1:0] SECOND_DMA_BASE_DWORD =
		SECOND_DMA_BASE_OFFSET[7:2];
	localparam logic [DWORD_ADDR_W-1:0] MISC_CONFIG_DWORD = MISC_CONFIG_OFFSET[7:2];

	// byte lane within the dword where each register starts
	localparam int SECOND_DMA_BASE_LANE = 2;
	localparam int MISC_CONFIG_LANE = 0;

	// second dma base register layout (16 bits)
	localparam int BASE_ADDR_HI = 15;
	localparam int BASE_ADDR_LO = 7;
	localparam int BASE_CHAN_HI = 5;
	localparam int BASE_CHAN_LO = 4;
	localparam int BASE_ENABLE_BIT = 0;
	localparam logic [7:0] BASE_LOW_BYTE_MASK = 8'hb1;
	localparam logic [7:0] BASE_HIGH_BYTE_MASK = 8'hff;
	localparam logic [15:0] SECOND_DMA_BASE_RESET = 16'h0000;

	// miscellaneous configuration register layout (8 bits)
	localparam int MISC_DUTY_HI = 7;
	localparam int MISC_DUTY_LO = 6;
	localparam int MISC_RETRY_BIT = 5;
	localparam int MISC_SCP_CLOCK_BIT = 4;
	localparam int MISC_BUS_HOG_BIT = 3;
	localparam int MISC_CHAN_HI = 2;
	localparam int MISC_CHAN_LO = 1;
	localparam int MISC_SIDEBAND_BIT = 0;
	localparam logic [7:0] MISC_CONFIG_MASK = 8'hff;
	localparam logic [7:0] MISC_CONFIG_RESET = 8'h00;

	// serial configuration port clock
	localparam int CLOCK_HZ = 20_000_000;
	localparam int SCP_CLOCK_HZ = 400_000;
	localparam int SCP_HALF_CYCLES = CLOCK_HZ / (2 * SCP_CLOCK_HZ);
	localparam int SCP_COUNT_W = 5;
	localparam logic [SCP_COUNT_W-1:0] SCP_HALF_LAST = SCP_COUNT_W'(SCP_HALF_CYCLES - 1);
	localparam logic [SCP_COUNT_W-1:0] SCP_COUNT_RESET = 5'h00;

endpackage

// >>> design/serial_cfg_clock.sv
/*
 * serial configuration port clock: a 400 KHz divided clock or the system
 * clock itself, plus the sampling of incoming serial data on the rising
 * edge of the divided clock.
 * assumes clock_i is the 20 MHz pci clock and data_i is an asynchronous pin.
 */
`timescale 1ns/100ps

module serial_cfg_clock
	import cfg_space_pkg::*;
(
	input wire logic clock_i, // system clock
	input wire logic reset_i, // synchronous reset, active high
	input wire logic pci_clock_sel_i, // 1 = pass pci clock, 0 = 400 KHz
	input wire logic data_i, // serial data pin
	output logic scp_clock_o, // clock toward the serial port
	output logic data_o, // sampled serial data
	output logic sample_o // pulse when data_o was refreshed, 400 KHz mode only
);
	logic [SCP_COUNT_W-1:0] count_q;
	logic [SCP_COUNT_W-1:0] count_d;
	logic slow_q;
	logic data_meta_q;
	logic data_sync_q;
	logic data_q;
	logic half_done;
	logic rise;

	// divider: toggle the slow clock every half period
	assign half_done = (count_q == SCP_HALF_LAST);
	assign count_d = half_done ? SCP_COUNT_RESET : count_q + 1'b1;
	assign rise = half_done && !slow_q;

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			count_q <= SCP_COUNT_RESET;
			slow_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			slow_q <= half_done ? !slow_q : slow_q;
		end
	end

	// pin passes two flops; data is then latched on the slow clock's rise
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			data_meta_q <= 1'b0;
			data_sync_q <= 1'b0;
			data_q <= 1'b0;
			sample_o <= 1'b0;
		end
		else
		begin
			data_meta_q <= data_i;
			data_sync_q <= data_meta_q;
			data_q <= rise ? data_sync_q : data_q;
			sample_o <= rise && !pci_clock_sel_i;
		end
	end

	// the clock mux glitches on a select change; software switches it while idle
	assign scp_clock_o = pci_clock_sel_i ? clock_i : slow_q;
	assign data_o = data_q;

endmodule

// >>> sim/regs_chk.sv
/*
 * checker for the dma base and misc configuration registers.
 * assumes one pci clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module regs_chk (
	input wire logic clock_i, // clock
	input wire logic reset_i, // reset
	input wire logic cfg_rd_i, // read
	input wire logic cfg_wr_i, // write
	input wire logic cfg_ack_o, // ack
	input wire logic synth_queue_first_hit_i, // hit 1
	input wire logic synth_queue_second_hit_i, // hit 2
	input wire logic synth_queue_first_full_i, // full 1
	input wire logic synth_queue_second_full_i, // full 2
	input wire logic synth_retry_o, // retry
	input wire logic serial_cfg_port_clock_sel_o, // clock select
	input wire logic scp_clock_o, // serial clock
	input wire logic sideband_dma_mode_on_o, // mode
	input wire logic [1:0] legacy_dma_channel_code_o, // code
	input wire logic legacy_dma_req_i, // request
	input wire logic sideband_req_o, // sideband request
	input wire logic sideband_gnt_i, // grant pin
	input wire logic legacy_dma_gnt_o // grant
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence access_s;
		cfg_rd_i || cfg_wr_i;
	endsequence
	// every strobe gets exactly one ack one cycle later
	ack_follows_a: assert property (access_s |=> cfg_ack_o) else $error("ack missing");
	no_spur_ack_a: assert property (!(cfg_rd_i || cfg_wr_i) |=> !cfg_ack_o)
		else $error("ack without access");
	retry_cause_a: assert property (synth_retry_o |-> (synth_queue_first_hit_i &&
		synth_queue_first_full_i) || (synth_queue_second_hit_i && synth_queue_second_full_i))
		else $error("retry without full hit");
	sb_request_a: assert property (sideband_req_o == (sideband_dma_mode_on_o &&
		legacy_dma_req_i)) else $error("sideband request wrong");
	code_gated_a: assert property (!sideband_dma_mode_on_o |->
		legacy_dma_channel_code_o == 2'h0) else $error("code leaks");
	// three sync edges, so four sampled highs must show the grant
	grant_latency_a: assert property ((sideband_gnt_i && sideband_dma_mode_on_o) [*4]
		|=> legacy_dma_gnt_o) else $error("grant late");
	grant_off_a: assert property (!sideband_dma_mode_on_o [*2] |=> !legacy_dma_gnt_o)
		else $error("grant while off");
	// select may change mid phase, so it excuses the check; a select that has
	// just fallen shows the slow clock mid phase, which is no real rise
	slow_half_a: assert property ($rose(scp_clock_o) && !serial_cfg_port_clock_sel_o &&
		!$past(serial_cfg_port_clock_sel_o) |->
		##24 (scp_clock_o || serial_cfg_port_clock_sel_o) ##1
		(!scp_clock_o || serial_cfg_port_clock_sel_o)) else $error("slow clock phase");
endmodule
bind legacy_dma_misc_config_regs regs_chk u_chk (.*);

// >>> sim/chipset_model.sv
/*
 * chipset side of the sideband dma pins: grants a request after a wait.
 * assumes the request comes from the block on the same clock.
 */
`timescale 1ns/100ps
module chipset_model (
	input wire logic clock_i, // pci clock
	input wire logic reset_i, // reset
	input wire logic req_i, // sideband request
	input wire logic [3:0] wait_i, // grant delay in cycles
	output logic gnt_o // sideband grant
);
	logic [3:0] cnt_q;
	// saturating wait counter; a dropped request withdraws the grant at once
	always_ff @(posedge clock_i)
	begin
		if (reset_i || !req_i)
			cnt_q <= 4'h0;
		else if (cnt_q != 4'hf)
			cnt_q <= cnt_q + 4'h1;
	end
	assign gnt_o = req_i && (cnt_q > wait_i);
endmodule

// >>> sim/legacy_dma_misc_config_regs_tb_top.sv
/*
 * testbench for the dma base and misc configuration registers.
 * assumes the chipset model and the bound checker.
 */
`timescale 1ns/100ps
module legacy_dma_misc_config_regs_tb_top;
	import cfg_space_pkg::*;
	logic clock_i = 0, reset_i = 1, cfg_rd_i = 0, cfg_wr_i = 0, cfg_ack_o;
	logic [5:0] cfg_dword_i = 0;
	logic [3:0] cfg_be_i = 0, gnt_wait = 0;
	logic [31:0] cfg_wdata_i = 0, cfg_rdata_o;
	logic [8:0] second_dma_base_o;
	logic [1:0] second_dma_chan_o, dsp_clock_duty_sel_o, legacy_dma_channel_code_o;
	logic second_dma_on_o, bus_hog_fix_on_o, synth_retry_o, serial_cfg_port_clock_sel_o;
	logic synth_queue_first_hit_i = 0, synth_queue_second_hit_i = 0;
	logic synth_queue_first_full_i = 0, synth_queue_second_full_i = 0;
	logic scp_clock_o, scp_data_i = 0, scp_data_o, scp_sample_o, sideband_dma_mode_on_o;
	logic legacy_dma_req_i = 0, sideband_req_o, sideband_gnt_i, legacy_dma_gnt_o;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	logic [7:0] tbl [4] = '{8'hc1, 8'h45, 8'h86, 8'h38};
	legacy_dma_misc_config_regs u_dut (.*);
	chipset_model u_chip (.clock_i(clock_i), .reset_i(reset_i), .req_i(sideband_req_o),
		.wait_i(gnt_wait), .gnt_o(sideband_gnt_i));
	always #25 clock_i = !clock_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one strobe cycle; ack and read data are looked at while ack stands
	task automatic acc(input logic wr, input logic [5:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clock_i);
		cfg_wr_i = wr;
		cfg_rd_i = !wr;
		cfg_dword_i = a;
		cfg_be_i = be;
		cfg_wdata_i = d;
		@(negedge clock_i);
		cfg_wr_i = 0;
		cfg_rd_i = 0;
		chk(cfg_ack_o, 1);
	endtask
	task automatic base_reg;
		acc(0, 6'h10, 4'hf, 0);
		chk(cfg_rdata_o, 0);
		acc(1, 6'h10, 4'hc, 32'hffff_0000); // all ones, as channel a would hold
		acc(0, 6'h10, 4'hf, 0);
		chk(cfg_rdata_o, 32'hffb1_0000);
		chk(second_dma_base_o, 9'h1ff);
		chk(second_dma_on_o, 1);
		acc(1, 6'h10, 4'h4, 32'h0020_0000); // channel 2, unlike channel a
		chk(second_dma_chan_o, 2'h2);
		chk(second_dma_base_o, 9'h1fe);
		chk(second_dma_on_o, 0);
		acc(0, 6'h00, 4'hf, 0);
		chk(cfg_rdata_o, 0);
	endtask
	// each table value drives every misc field; upper lanes must read zero
	task automatic misc_reg;
		logic [7:0] v;
		acc(0, 6'h16, 4'hf, 0);
		chk(cfg_rdata_o, 0);
		for (int i = 0; i < 4; i++)
		begin
			v = tbl[i];
			acc(1, 6'h16, 4'hf, {24'hffffff, v});
			acc(0, 6'h16, 4'hf, 0);
			chk(cfg_rdata_o, {24'h0, v});
			chk(dsp_clock_duty_sel_o, v[7:6]);
			chk(serial_cfg_port_clock_sel_o, v[4]);
			chk(bus_hog_fix_on_o, v[3]);
			chk(sideband_dma_mode_on_o, v[0]);
			chk(legacy_dma_channel_code_o, v[0] ? v[2:1] : 2'h0);
		end
	endtask
	task automatic retry_chk;
		for (int k = 0; k < 2; k++)
		begin
			acc(1, 6'h16, 4'h1, k ? 32'h20 : 32'h0);
			for (int j = 0; j < 16; j++)
			begin
				@(negedge clock_i);
				{synth_queue_first_hit_i, synth_queue_first_full_i} = j[3:2];
				{synth_queue_second_hit_i, synth_queue_second_full_i} = j[1:0];
				#1;
				chk(synth_retry_o, k & ((j[3] & j[2]) | (j[1] & j[0])));
			end
		end
		@(negedge clock_i);
		{synth_queue_first_hit_i, synth_queue_first_full_i} = 2'h0;
		{synth_queue_second_hit_i, synth_queue_second_full_i} = 2'h0;
	endtask
	// slow grant: none while the chipset waits, then it reaches the block
	task automatic sideband;
		acc(1, 6'h16, 4'h1, 32'h3);
		gnt_wait = 4'h9;
		legacy_dma_req_i = 1;
		repeat (4) @(negedge clock_i);
		chk(sideband_req_o, 1);
		chk(legacy_dma_gnt_o, 0);
		repeat (12) @(negedge clock_i);
		chk(legacy_dma_gnt_o, 1);
		acc(1, 6'h16, 4'h1, 32'h0);
		repeat (4) @(negedge clock_i);
		chk(sideband_req_o, 0);
		chk(legacy_dma_gnt_o, 0);
		legacy_dma_req_i = 0;
	endtask
	// 200 cycles hold exactly four rises and four samples of the 400 KHz clock
	task automatic serial_port;
		int rises;
		int pulses;
		logic prev;
		rises = 0;
		pulses = 0;
		prev = scp_clock_o;
		scp_data_i = 1;
		repeat (200)
		begin
			@(negedge clock_i);
			rises += int'(scp_clock_o && !prev);
			pulses += int'(scp_sample_o);
			prev = scp_clock_o;
		end
		chk(rises, 4);
		chk(pulses, 4);
		chk(scp_data_o, 1);
		scp_data_i = 0;
		repeat (120) @(negedge clock_i);
		chk(scp_data_o, 0);
		// pci clock mode: high after a rising edge, low after the falling one
		acc(1, 6'h16, 4'h1, 32'h10);
		@(posedge clock_i);
		#1;
		chk(scp_clock_o, 1);
		@(negedge clock_i);
		chk(scp_clock_o, 0);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// a hang costs one mismatch and ends the run
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	initial
	begin
		repeat (12) @(negedge clock_i);
		reset_i = 0;
		base_reg();
		misc_reg();
		retry_chk();
		sideband();
		serial_port();
		complete_run();
	end
endmodule
